// [include/rtcs_pkg.sv]
// Purpose: Shared constants and carrier types for the clock-chip serial slave port
// Assumes: 50 MHz core clock, bus lines sampled by the core clock
// Notes: Register contents live outside; the port offers pointer, data and strobes
package rtcs_pkg;
    localparam logic [6:0] SLAVE_ADDR = 7'h51;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] ACK_SLOT = 4'h8;

    typedef enum logic [5:0] {
        RTCS_IDLE = 6'b000001,
        RTCS_ADDR = 6'b000010,
        RTCS_ADDR_ACK = 6'b000100,
        RTCS_RX = 6'b001000,
        RTCS_TX = 6'b010000,
        RTCS_WAIT = 6'b100000
    } rtcs_state_t;

    typedef struct packed {
        logic [7:0] ptr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rtcs_reg_req_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } rtcs_bus_t;
endpackage

// [core/rtcs_slave.sv]
// Purpose: Serial two-wire slave port giving byte access to the clock registers
// Assumes: Bus lines come asynchronously from pins; register file answers within a cycle
// Notes: Pins are open drain; output enable low means the line is pulled low
`timescale 1ns/10ps
// Contract
// - Idle leaves both lines released so they rest high.
// - Lines are only pulled low or released, open-drain style.
// - SDA falling while SCL high is start; a new transfer begins.
// - SDA rising while SCL high is stop; the transfer ends.
// - A start before any stop is taken as repeated start.
// - Transmit changes SDA while SCL low; receive samples on SCL high.
// - SDA change during SCL high is a condition, never a data bit.
// - Bytes are eight bits; any number may follow a start.
// - Pointer advances by one after each byte, read or write.
// - After the eighth falling edge transmitter releases; receiver acknowledges low.
// - Acknowledger releases SDA at the ninth falling edge.
// - Master no-acknowledge ends the read; device releases and waits for stop.
// - Only a matching seven-bit address is acknowledged; else ignore until start.
// - Address byte holds address in bits seven to one, read as bit zero.
module rtcs_slave (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Bus pins
    input wire logic SCL_IN,
    output logic SCL_OUT,
    output logic SCL_OE_N,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N,
    // Register file side
    output rtcs_pkg::rtcs_reg_req_t REG_REQ,
    input wire logic [7:0] REG_RDATA,
    output logic BUSY
);
    import rtcs_pkg::*;

    typedef struct packed {
        rtcs_bus_t s1;
        rtcs_bus_t s2;
        rtcs_bus_t last;
        rtcs_state_t state;
        logic [3:0] bitcnt;
        logic [7:0] shift;
        logic rw;
        logic first;
        logic ack_ok;
        logic sda_low;
        rtcs_reg_req_t req;
        logic busy;
    } rtcs_st_t;

    localparam rtcs_st_t ST_RESET = '{
        s1: '{scl: 1'b1, sda: 1'b1},
        s2: '{scl: 1'b1, sda: 1'b1},
        last: '{scl: 1'b1, sda: 1'b1},
        state: RTCS_IDLE,
        bitcnt: 4'h0,
        shift: 8'h00,
        rw: 1'b0,
        first: 1'b0,
        ack_ok: 1'b0,
        sda_low: 1'b0,
        req: '{ptr: PTR_RESET, wdata: 8'h00, wr: 1'b0, rd: 1'b0},
        busy: 1'b0
    };

    logic rst_s1;
    logic rst_n;
    rtcs_st_t st;
    rtcs_st_t next_st;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two stages
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge and condition detection on the twice-synchronised copy
    always_comb begin
        scl_rise = st.s2.scl && !st.last.scl;
        scl_fall = !st.s2.scl && st.last.scl;
        // SDA moving while SCL stays high is a condition
        start_seen = st.s2.scl && st.last.scl && st.last.sda && !st.s2.sda;
        stop_seen = st.s2.scl && st.last.scl && !st.last.sda && st.s2.sda;
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_st.s1 = '{scl: SCL_IN, sda: SDA_IN};
        next_st.s2 = st.s1;
        next_st.last = st.s2;
        next_st.req.wr = 1'b0;
        next_st.req.rd = 1'b0;
        if (start_seen) begin
            // Also covers a start with no stop before it
            next_st.state = RTCS_ADDR;
            next_st.bitcnt = 4'h0;
            next_st.sda_low = 1'b0;
            next_st.busy = 1'b1;
        end else if (stop_seen) begin
            next_st.state = RTCS_IDLE;
            next_st.sda_low = 1'b0;
            next_st.busy = 1'b0;
        end else begin
            unique case (st.state)
                RTCS_IDLE, RTCS_WAIT: begin
                    next_st.sda_low = 1'b0;
                end
                RTCS_ADDR, RTCS_RX: begin
                    if (scl_rise && st.bitcnt < BITS_PER_BYTE) begin
                        next_st.shift = {st.shift[6:0], st.s2.sda};
                        next_st.bitcnt = st.bitcnt + 4'h1;
                    end
                    if (scl_fall && st.bitcnt == BITS_PER_BYTE && !st.sda_low) begin
                        if (st.state == RTCS_ADDR) begin
                            if (st.shift[7:1] == SLAVE_ADDR) begin
                                next_st.sda_low = 1'b1;
                                next_st.rw = st.shift[0];
                                next_st.first = 1'b1;
                                next_st.state = RTCS_ADDR_ACK;
                            end else begin
                                next_st.state = RTCS_WAIT;
                            end
                        end else begin
                            next_st.sda_low = 1'b1;
                            if (st.first) begin
                                next_st.req.ptr = st.shift;
                                next_st.first = 1'b0;
                            end else begin
                                next_st.req.wdata = st.shift;
                                next_st.req.wr = 1'b1;
                            end
                        end
                    end else if (scl_fall && st.sda_low) begin
                        next_st.sda_low = 1'b0;
                        next_st.bitcnt = 4'h0;
                    end
                end
                RTCS_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_st.bitcnt = 4'h0;
                        if (st.rw) begin
                            next_st.state = RTCS_TX;
                            next_st.shift = REG_RDATA;
                            next_st.req.rd = 1'b1;
                            next_st.sda_low = !REG_RDATA[7];
                        end else begin
                            next_st.state = RTCS_RX;
                            next_st.sda_low = 1'b0;
                        end
                    end
                end
                RTCS_TX: begin
                    if (scl_fall) begin
                        if (st.bitcnt < BITS_PER_BYTE - 4'h1) begin
                            next_st.bitcnt = st.bitcnt + 4'h1;
                            next_st.shift = {st.shift[6:0], 1'b0};
                            next_st.sda_low = !st.shift[6];
                        end else if (st.bitcnt == BITS_PER_BYTE - 4'h1) begin
                            next_st.bitcnt = ACK_SLOT;
                            next_st.sda_low = 1'b0;
                            next_st.req.ptr = st.req.ptr + 8'h01;
                        end else begin
                            // Ninth falling edge: next byte or quiet wait
                            next_st.bitcnt = 4'h0;
                            if (st.ack_ok) begin
                                next_st.shift = REG_RDATA;
                                next_st.req.rd = 1'b1;
                                next_st.sda_low = !REG_RDATA[7];
                            end else begin
                                next_st.state = RTCS_WAIT;
                                next_st.sda_low = 1'b0;
                            end
                        end
                    end
                    if (scl_rise && st.bitcnt == ACK_SLOT) begin
                        next_st.ack_ok = !st.s2.sda;
                    end
                end
                default: begin
                    next_st.state = RTCS_IDLE;
                    next_st.sda_low = 1'b0;
                end
            endcase
        end
        // Pointer step after each written data byte, the cycle after its write strobe
        if (st.req.wr) begin
            next_st.req.ptr = st.req.ptr + 8'h01;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Open-drain outputs: only low or released, never driven high
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            SDA_OE_N <= 1'b1;
            SCL_OE_N <= 1'b1;
            SDA_OUT <= 1'b0;
            SCL_OUT <= 1'b0;
            REG_REQ <= '0;
            BUSY <= 1'b0;
        end else begin
            SDA_OE_N <= !next_st.sda_low;
            SCL_OE_N <= 1'b1;
            SDA_OUT <= 1'b0;
            SCL_OUT <= 1'b0;
            REG_REQ <= next_st.req;
            BUSY <= next_st.busy;
        end
    end
endmodule

// [testbench/rtcs_sva.sv]
// Purpose: Pin and strobe timing checks on the serial slave port
// Assumes: Raw pins seen; slave events land a few core cycles late
// Notes: Bound onto every slave instance
`timescale 1ns/10ps
module rtcs_sva (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Bus pins
    input wire logic SCL_IN,
    input wire logic SCL_OUT,
    input wire logic SCL_OE_N,
    input wire logic SDA_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE_N,
    // Register side
    input wire rtcs_pkg::rtcs_reg_req_t REG_REQ,
    input wire logic [7:0] REG_RDATA,
    input wire logic BUSY
);
    import rtcs_pkg::*;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    ////////////////////////////////////////
    a_open_drain: assert property (SCL_OE_N && !SCL_OUT && !SDA_OUT)
        else $error("pin driven high or clock pulled");
    a_idle_release: assert property (!BUSY && !$past(BUSY) |-> SDA_OE_N)
        else $error("data line pulled while idle");
    a_start_busy: assert property ($fell(SDA_IN) && SCL_IN |-> ##[1:6] BUSY)
        else $error("start not taken");
    a_stop_idle: assert property ($rose(SDA_IN) && SCL_IN |-> ##[1:6] !BUSY)
        else $error("stop not taken");
    a_oe_scl_low: assert property ($changed(SDA_OE_N) |-> !SCL_IN)
        else $error("data changed with clock high");
    a_ack_hold: assert property ($fell(SDA_OE_N) |=> !SDA_OE_N [*4])
        else $error("low drive too short");
    a_wr_single: assert property (REG_REQ.wr |=> !REG_REQ.wr)
        else $error("write strobe too long");
    a_ptr_step: assert property (REG_REQ.wr |=> REG_REQ.ptr == $past(REG_REQ.ptr) + 8'h01)
        else $error("pointer did not step");
endmodule
bind rtcs_slave rtcs_sva i_rtcs_sva (.CLK(CLK), .RESETN(RESETN), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT),
    .SCL_OE_N(SCL_OE_N), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .REG_REQ(REG_REQ),
    .REG_RDATA(REG_RDATA), .BUSY(BUSY));

// [testbench/rtcs_master.sv]
// Purpose: Behavioural bus master for the serial slave port
// Assumes: Lines resolved with pull-ups by the bench
// Notes: 160 ns bit of eight core clocks; long low phase so slave answers settle first
`timescale 1ns/10ps
module rtcs_master (
    // Bench clock, every change made just after its rising edge
    input wire logic CLK,
    // Line drives, 0 pulls low
    output logic scl_o,
    output logic sda_o,
    // Resolved data line
    input wire logic sda_i
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    ////////////////////////////////////////
    // Clock rises only after the slave has let go of its ack
    task automatic start_c();
        @(posedge CLK);
        sda_o <= 1'b1;
        repeat (4) @(posedge CLK);
        scl_o <= 1'b1;
        repeat (4) @(posedge CLK);
        sda_o <= 1'b0;
        repeat (4) @(posedge CLK);
        scl_o <= 1'b0;
    endtask
    task automatic stop_c();
        @(posedge CLK);
        sda_o <= 1'b0;
        repeat (4) @(posedge CLK);
        scl_o <= 1'b1;
        repeat (4) @(posedge CLK);
        sda_o <= 1'b1;
        repeat (4) @(posedge CLK);
    endtask
    task automatic bitx(input logic b, output logic r);
        @(posedge CLK);
        sda_o <= 1'b1;
        repeat (3) @(posedge CLK);
        sda_o <= b;
        repeat (2) @(posedge CLK);
        scl_o <= 1'b1;
        @(posedge CLK);
        r = sda_i;
        @(posedge CLK);
        scl_o <= 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, ack);
    endtask
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(nack, r);
    endtask
endmodule

// [testbench/tb_top.sv]
// Purpose: Self-checking bench for the serial slave port
// Assumes: Register file modelled here, answers at once
// Notes: Reads check random bytes written earlier
`timescale 1ns/10ps
module tb_top;
    import rtcs_pkg::*;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic ms, md, ack, busy, scl_oe_n, sda_oe_n;
    logic [7:0] d, regs [256], wd [4];
    logic [7:0] bad [4] = '{8'ha0, 8'ha4, 8'h22, 8'he3};
    logic [15:0] qw [$];
    logic [7:0] qr [$];
    logic [31:0] seed = 32'h4bc6;
    int err_total = 0;
    int n_checks = 0;
    rtcs_reg_req_t req;
    wire scl = ms & scl_oe_n;
    wire sda = md & sda_oe_n;
    always #10 CLK = ~CLK;
    rtcs_slave i_rtcs_slave (.CLK(CLK), .RESETN(RESETN), .SCL_IN(scl), .SCL_OUT(), .SCL_OE_N(scl_oe_n),
        .SDA_IN(sda), .SDA_OUT(), .SDA_OE_N(sda_oe_n), .REG_REQ(req), .REG_RDATA(regs[req.ptr]), .BUSY(busy));
    rtcs_master i_rtcs_master (.CLK(CLK), .scl_o(ms), .sda_o(md), .sda_i(sda));
    ////////////////////////////////////////
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic xfer(input logic [7:0] b, input logic e);
        i_rtcs_master.wbyte(b, ack);
        chk("ack", e, ack);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    // Register file and strobe watcher; empty queue means an unexpected strobe
    always @(posedge CLK) begin
        if (req.wr === 1'b1) begin
            regs[req.ptr] <= req.wdata;
            chk("wr", qw.size() ? qw.pop_front() : 16'hxxxx, {req.ptr, req.wdata});
        end
        if (req.rd === 1'b1) begin
            chk("rd", qr.size() ? qr.pop_front() : 8'hxx, req.ptr);
        end
    end
    initial begin
        repeat (100000) @(posedge CLK);
        err_total++;
        stop_test();
    end
    initial begin
        foreach (regs[i]) regs[i] = 8'h00;
        repeat (4) @(posedge CLK);
        RESETN <= 1'b1;
        repeat (8) @(posedge CLK);
        i_rtcs_master.start_c();
        chk("busy", 1, busy);
        xfer(8'ha2, 1'b0);
        xfer(8'h10, 1'b0);
        for (int k = 0; k < 4; k++) begin
            wd[k] = rnd();
            qw.push_back({8'h10 + 8'(k), wd[k]});
            xfer(wd[k], 1'b0);
        end
        i_rtcs_master.stop_c();
        repeat (8) @(posedge CLK);
        chk("idle", 0, busy);
        $display("test 1 done");
        i_rtcs_master.start_c();
        xfer(8'ha2, 1'b0);
        xfer(8'h10, 1'b0);
        i_rtcs_master.start_c();
        // First fetch strobes at the falling edge ending the address ack, so note it first
        for (int k = 0; k < 3; k++) qr.push_back(8'h10 + 8'(k));
        xfer(8'ha3, 1'b0);
        for (int k = 0; k < 3; k++) begin
            i_rtcs_master.rbyte(k == 2, d);
            chk("rdata", wd[k], d);
        end
        i_rtcs_master.stop_c();
        $display("test 2 done");
        i_rtcs_master.start_c();
        qr.push_back(8'h13);
        xfer(8'ha3, 1'b0);
        i_rtcs_master.rbyte(1'b1, d);
        chk("rdata", wd[3], d);
        i_rtcs_master.stop_c();
        $display("test 3 done");
        for (int k = 0; k < 4; k++) begin
            i_rtcs_master.start_c();
            xfer(bad[k], 1'b1);
            xfer(rnd(), 1'b1);
            i_rtcs_master.stop_c();
        end
        $display("test 4 done");
        chk("left", 0, 16'(qw.size() + qr.size()));
        stop_test();
    end
endmodule
